// ===== core/cise_pkg.sv
//----------------------------------------------------------------------
// Overview of operation
// [RULE_01] Watchdog kick resets watchdog counter to zero
// [RULE_02] Watchdog kick also zeroes the watchdog prescaler
// [RULE_03] Watchdog kick sets expiry and powerdown flags
// [RULE_04] Indirect call pushes PC plus one
// [RULE_05] Indirect call loads PC from latch and accumulator
// [RULE_06] Indirect call: two cycles, flags untouched
// [RULE_07] Invert file to selected destination, zero flag updated
// [RULE_08] Zero file clears register, sets zero flag
// [RULE_09] Decrement file to selected destination, updates zero
// [RULE_10] Zero accumulator clears it, sets zero flag
// [RULE_11] Decrement-skip: no flags, zero result skips next
// [RULE_12] Zero flag follows result; others single cycle
//----------------------------------------------------------------------
package cise_pkg;

   //-------------------------------------------------------------------
   // Instruction set subset and operand carrier
   //-------------------------------------------------------------------
   typedef enum logic [2:0] {
      NOP_OP                  = 3'h0,
      KICK_WATCHDOG_OP        = 3'h1,
      INDIRECT_CALL_OP        = 3'h2,
      INVERT_FILE_OP          = 3'h3,
      ZERO_FILE_OP            = 3'h4,
      FILE_DECREMENT_OP       = 3'h5,
      ZERO_ACCUMULATOR_OP     = 3'h6,
      DECREMENT_SKIP_ZERO_OP  = 3'h7
   } cise_opcode_t;

   typedef struct packed {
      cise_opcode_t code;
      logic         dest;       // 0: accumulator, 1: file register
      logic [6:0]   file_addr;
   } cise_op_t;

   // Sequencer states, one-hot
   typedef enum logic [1:0] {
      ST_EXEC   = 2'b01,
      ST_SECOND = 2'b10
   } cise_state_t;

   //-------------------------------------------------------------------
   // Register map of the plain register port
   //-------------------------------------------------------------------
   localparam logic [7:0] ADDR_ACC       = 8'h00;
   localparam logic [7:0] ADDR_STATUS    = 8'h01;
   localparam logic [7:0] ADDR_PC_LATCH  = 8'h02;
   localparam logic [7:0] ADDR_PC_LO     = 8'h03;
   localparam logic [7:0] ADDR_PC_HI     = 8'h04;
   localparam logic [7:0] ADDR_WDT_CNT   = 8'h05;
   localparam logic [7:0] ADDR_WDT_PRE   = 8'h06;
   localparam logic [7:0] ADDR_TOS_LO    = 8'h07;
   localparam logic [7:0] ADDR_TOS_HI    = 8'h08;
   localparam logic [7:0] ADDR_STACK_PTR = 8'h09;
   localparam logic [7:0] ADDR_FILE_BASE = 8'h80;

   // Status register bit positions
   localparam int STAT_ZERO   = 0;
   localparam int STAT_EXPIRY = 1;
   localparam int STAT_PWRDN  = 2;

   // Reset and constant values
   localparam logic [7:0]  BYTE_ZERO    = 8'h00;
   localparam logic [7:0]  BYTE_ONE     = 8'h01;
   localparam logic [14:0] PC_RESET     = 15'h0000;
   localparam logic [14:0] PC_STEP      = 15'h0001;
   localparam logic        FLAG_SET_N   = 1'b1;
   localparam logic        DEST_ACC     = 1'b0;

endpackage

// ===== core/cise_exec.sv
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
module cise_exec
   import cise_pkg::*;
#(
   parameter int PRESCALE_W   = 7,
   parameter int WDT_W        = 8,
   parameter int STACK_DEPTH  = 16,
   parameter int STACK_PTR_W  = 4
)(
   input  wire logic        i_clk,
   input  wire logic        i_resetn,
   // Instruction issue
   input  wire logic        i_op_valid,
   input  wire cise_op_t    i_op,
   output logic             o_op_ready,
   // Register port
   input  wire logic [7:0]  i_addr,
   input  wire logic [7:0]  i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [7:0]  o_rdata,
   // Core state
   output logic      [14:0] o_pc,
   output logic      [7:0]  o_accumulator,
   output logic             o_zero_flag,
   output logic             o_watchdog_expiry_flag_n,
   output logic             o_powerdown_flag_n,
   output logic             o_skip,
   output logic             o_watchdog_timeout
);

   //-------------------------------------------------------------------
   // Storage
   //-------------------------------------------------------------------
   logic [7:0]             file_mem [128];
   logic [14:0]            stack_mem [STACK_DEPTH];
   logic [STACK_PTR_W-1:0] stack_ptr_reg;
   logic [7:0]             acc_reg;
   logic [6:0]             upper_pc_latch_reg;
   logic [14:0]            pc_reg;
   logic                   zero_reg;
   logic                   expiry_n_reg;
   logic                   powerdown_n_reg;
   logic [WDT_W-1:0]       watchdog_counter_reg;
   logic [PRESCALE_W-1:0]  prescale_reg;
   logic                   skip_reg;
   logic                   timeout_reg;
   logic [7:0]             rdata_reg;
   cise_state_t            state_reg;
   cise_state_t            state_next;

   //-------------------------------------------------------------------
   // Decode and datapath
   //-------------------------------------------------------------------
   logic       take;
   logic [7:0] file_val;
   logic [7:0] result;
   logic       writes_acc;
   logic       writes_file;
   logic       updates_zero;
   logic       is_kick;
   logic       is_call;
   logic       skip_hit;
   logic       prescale_wrap;
   logic       watchdog_wrap;
   logic       bus_file;

   // A new instruction is only taken while no two-cycle op is finishing
   assign o_op_ready = (state_reg == ST_EXEC);
   assign take       = i_op_valid && o_op_ready;
   assign file_val   = file_mem[i_op.file_addr];
   assign bus_file   = (i_addr >= ADDR_FILE_BASE);

   // Result and destination per instruction
   // The file value is read straight from the addressed entry; a port
   // write to that entry only lands after the edge, so it is not seen
   always_comb begin
      result       = BYTE_ZERO;
      writes_acc   = 1'b0;
      writes_file  = 1'b0;
      updates_zero = 1'b0;
      is_kick      = 1'b0;
      is_call      = 1'b0;
      skip_hit     = 1'b0;
      if (take) begin
         case (i_op.code)
            KICK_WATCHDOG_OP: begin
               is_kick = 1'b1;
            end
            INDIRECT_CALL_OP: begin
               is_call = 1'b1;                            // RULE_06
            end
            INVERT_FILE_OP: begin
               result       = ~file_val;                  // RULE_07
               writes_acc   = (i_op.dest == DEST_ACC);
               writes_file  = (i_op.dest != DEST_ACC);
               updates_zero = 1'b1;
            end
            ZERO_FILE_OP: begin
               result       = BYTE_ZERO;                  // RULE_08
               writes_file  = 1'b1;
               updates_zero = 1'b1;
            end
            FILE_DECREMENT_OP: begin
               result       = file_val - BYTE_ONE;        // RULE_09
               writes_acc   = (i_op.dest == DEST_ACC);
               writes_file  = (i_op.dest != DEST_ACC);
               updates_zero = 1'b1;
            end
            ZERO_ACCUMULATOR_OP: begin
               result       = BYTE_ZERO;                  // RULE_10
               writes_acc   = 1'b1;
               updates_zero = 1'b1;
            end
            DECREMENT_SKIP_ZERO_OP: begin
               result      = file_val - BYTE_ONE;         // RULE_11
               writes_acc  = (i_op.dest == DEST_ACC);
               writes_file = (i_op.dest != DEST_ACC);
               skip_hit    = (result == BYTE_ZERO);       // RULE_11
            end
            default: begin
               result = BYTE_ZERO;
            end
         endcase
      end
   end

   //-------------------------------------------------------------------
   // Sequencer
   //-------------------------------------------------------------------
   // Call and a taken skip both spend one extra cycle
   always_comb begin
      case (state_reg)
         ST_EXEC: begin
            if (is_call || skip_hit) begin
               state_next = ST_SECOND;                    // RULE_06
            end else begin
               state_next = ST_EXEC;                      // RULE_12
            end
         end
         ST_SECOND: begin
            state_next = ST_EXEC;
         end
         default: begin
            state_next = ST_EXEC;
         end
      endcase
   end

   // Reset always lands in the issue state, so ready is high at once
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         state_reg <= ST_EXEC;
      end else begin
         state_reg <= state_next;
      end
   end

   //-------------------------------------------------------------------
   // Program counter and return stack
   //-------------------------------------------------------------------
   // The skipped slot still advances the PC, as the NOP takes its place
   // A call is only flagged when taken, so it never adds the plain step
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         pc_reg <= PC_RESET;
      end else if (is_call) begin
         pc_reg <= {upper_pc_latch_reg, acc_reg};         // RULE_05
      end else if (take) begin
         pc_reg <= pc_reg + PC_STEP;
      end else if (state_reg == ST_SECOND && skip_reg) begin
         pc_reg <= pc_reg + PC_STEP;                      // RULE_11
      end
   end

   // Push before the jump; the pointer wraps on overflow like a ring
   // No underflow guard: returns lie outside this subset, and entries
   // are not reset, so the stack top shows junk before the first call
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         stack_ptr_reg <= '0;
      end else if (is_call) begin
         stack_mem[stack_ptr_reg] <= pc_reg + PC_STEP;    // RULE_04
         stack_ptr_reg            <= stack_ptr_reg + 1'b1;
      end
   end

   //-------------------------------------------------------------------
   // Accumulator, upper PC latch and file registers
   //-------------------------------------------------------------------
   // Instruction writes win over a register port write in the same cycle
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         acc_reg <= BYTE_ZERO;
      end else if (writes_acc) begin
         acc_reg <= result;                               // RULE_07
      end else if (i_wr && i_addr == ADDR_ACC) begin
         acc_reg <= i_wdata;
      end
   end

   // Only software loads the latch; the call just reads it
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         upper_pc_latch_reg <= '0;
      end else if (i_wr && i_addr == ADDR_PC_LATCH) begin
         upper_pc_latch_reg <= i_wdata[6:0];
      end
   end

   // File array has no reset; software initialises it through the port
   always_ff @(posedge i_clk) begin
      if (writes_file) begin
         file_mem[i_op.file_addr] <= result;              // RULE_09
      end else if (i_wr && bus_file) begin
         file_mem[i_addr[6:0]] <= i_wdata;
      end
   end

   //-------------------------------------------------------------------
   // Status flags
   //-------------------------------------------------------------------
   // Decrement-skip and call leave the zero flag alone
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         zero_reg <= 1'b0;
      end else if (updates_zero) begin
         zero_reg <= (result == BYTE_ZERO);               // RULE_12
      end
   end

   // Expiry clears the flag; a kick masks the wrap in its own cycle
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         expiry_n_reg <= FLAG_SET_N;
      end else if (watchdog_wrap) begin
         expiry_n_reg <= 1'b0;
      end else if (is_kick) begin
         expiry_n_reg <= FLAG_SET_N;                      // RULE_03
      end
   end

   // Nothing in this subset enters powerdown, so only a kick writes it;
   // a sleep entry elsewhere in the core would be the one to clear it
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         powerdown_n_reg <= FLAG_SET_N;
      end else if (is_kick) begin
         powerdown_n_reg <= FLAG_SET_N;                   // RULE_03
      end
   end

   //-------------------------------------------------------------------
   // Watchdog counter and prescaler
   //-------------------------------------------------------------------
   // Period is 2**(PRESCALE_W+WDT_W) cycles; the kick masks the wrap so
   // the expiry flag can never clear in the cycle the kick sets it
   assign prescale_wrap = &prescale_reg;
   assign watchdog_wrap = prescale_wrap && (&watchdog_counter_reg)
                          && !is_kick;

   // Prescaler free-runs; a kick restarts it with the counter
   always_ff @(posedge i_clk) begin
      if (!i_resetn || is_kick) begin
         prescale_reg <= '0;                              // RULE_02
      end else begin
         prescale_reg <= prescale_reg + 1'b1;
      end
   end

   // Counter steps once per prescaler wrap and wraps itself at the end
   always_ff @(posedge i_clk) begin
      if (!i_resetn || is_kick) begin
         watchdog_counter_reg <= '0;                      // RULE_01
      end else if (prescale_wrap) begin
         watchdog_counter_reg <= watchdog_counter_reg + 1'b1;
      end
   end

   // Skip pulse marks the slot that the NOP fills
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         skip_reg <= 1'b0;
      end else begin
         skip_reg <= skip_hit;                            // RULE_11
      end
   end

   // Timeout pulse lasts one cycle; the expiry flag keeps the news
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         timeout_reg <= 1'b0;
      end else begin
         timeout_reg <= watchdog_wrap;
      end
   end

   //-------------------------------------------------------------------
   // Register port read
   //-------------------------------------------------------------------
   // Unmapped addresses read as zero
   // Data returns to zero after one cycle so a stale read never lingers
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         rdata_reg <= BYTE_ZERO;
      end else if (i_rd) begin
         if (bus_file) begin
            rdata_reg <= file_mem[i_addr[6:0]];
         end else begin
            case (i_addr)
               ADDR_ACC:       rdata_reg <= acc_reg;
               ADDR_STATUS:    rdata_reg <= {5'h00, powerdown_n_reg,
                                             expiry_n_reg, zero_reg};
               ADDR_PC_LATCH:  rdata_reg <= {1'b0, upper_pc_latch_reg};
               ADDR_PC_LO:     rdata_reg <= pc_reg[7:0];
               ADDR_PC_HI:     rdata_reg <= {1'b0, pc_reg[14:8]};
               ADDR_WDT_CNT:   rdata_reg <= 8'(watchdog_counter_reg);
               ADDR_WDT_PRE:   rdata_reg <= 8'(prescale_reg);
               ADDR_TOS_LO:    rdata_reg <= stack_mem[stack_ptr_reg
                                                      - 1'b1][7:0];
               ADDR_TOS_HI:    rdata_reg <= {1'b0, stack_mem[stack_ptr_reg
                                                      - 1'b1][14:8]};
               ADDR_STACK_PTR: rdata_reg <= 8'(stack_ptr_reg);
               default:        rdata_reg <= BYTE_ZERO;
            endcase
         end
      end else begin
         rdata_reg <= BYTE_ZERO;
      end
   end

   //-------------------------------------------------------------------
   // Outputs
   //-------------------------------------------------------------------
   // Every data output comes straight from a flip-flop
   assign o_rdata                  = rdata_reg;
   assign o_pc                     = pc_reg;
   assign o_accumulator            = acc_reg;
   assign o_zero_flag              = zero_reg;
   assign o_watchdog_expiry_flag_n = expiry_n_reg;
   assign o_powerdown_flag_n       = powerdown_n_reg;
   assign o_skip                   = skip_reg;
   assign o_watchdog_timeout       = timeout_reg;

endmodule

// ===== tb/cise_exec_chk.sv
`timescale 1ns/1ns
module cise_exec_chk
   import cise_pkg::*;
#(
   parameter int PRESCALE_W  = 7,
   parameter int WDT_W       = 8,
   parameter int STACK_DEPTH = 16,
   parameter int STACK_PTR_W = 4
)(
   input wire logic        i_clk,
   input wire logic        i_resetn,
   input wire logic        i_op_valid,
   input wire cise_op_t    i_op,
   input wire logic        o_op_ready,
   input wire logic [7:0]  i_addr,
   input wire logic [7:0]  i_wdata,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [7:0]  o_rdata,
   input wire logic [14:0] o_pc,
   input wire logic [7:0]  o_accumulator,
   input wire logic        o_zero_flag,
   input wire logic        o_watchdog_expiry_flag_n,
   input wire logic        o_powerdown_flag_n,
   input wire logic        o_skip,
   input wire logic        o_watchdog_timeout
);
   default clocking dc @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   //-------------------------------------------------------------------
   // Accepted instruction and its steps
   //-------------------------------------------------------------------
   // An offer only counts on an edge where the core can take it
   wire logic         take = i_op_valid && o_op_ready;
   wire cise_opcode_t code = i_op.code;

   sequence call_take_s;
      take && code == INDIRECT_CALL_OP;
   endsequence
   sequence stall_then_go_s;
      !o_op_ready ##1 o_op_ready;
   endsequence

   //-------------------------------------------------------------------
   // Properties
   //-------------------------------------------------------------------
   call_stall_a: assert property (call_take_s |=> stall_then_go_s)
      else $error("call did not stall exactly one cycle");
   call_target_a: assert property (call_take_s |=>
      o_pc[7:0] == $past(o_accumulator) && $stable(o_zero_flag))
      else $error("call target or zero flag wrong");
   kick_flags_a: assert property (take && code == KICK_WATCHDOG_OP |=>
      o_watchdog_expiry_flag_n && o_powerdown_flag_n
      ##0 !o_watchdog_timeout [*8])
      else $error("watchdog kick flags or restart wrong");
   zero_acc_a: assert property (take && code == ZERO_ACCUMULATOR_OP |=>
      o_accumulator == BYTE_ZERO && o_zero_flag)
      else $error("accumulator clear wrong");
   zero_file_a: assert property (take && code == ZERO_FILE_OP |=> o_zero_flag)
      else $error("file clear left zero flag low");
   acc_zero_a: assert property (take && i_op.dest == DEST_ACC &&
      (code == INVERT_FILE_OP || code == FILE_DECREMENT_OP)
      |=> o_zero_flag == (o_accumulator == BYTE_ZERO))
      else $error("zero flag does not follow accumulator");
   skip_flags_a: assert property (take && code == DECREMENT_SKIP_ZERO_OP
      |=> $stable(o_zero_flag) && $stable(o_powerdown_flag_n))
      else $error("decrement skip touched flags");
   skip_slot_a: assert property (o_skip |-> !o_op_ready
      ##1 (o_op_ready && o_pc == $past(o_pc) + PC_STEP))
      else $error("skip slot stall or pc advance wrong");
   pc_step_a: assert property (take && !i_wr && code != INDIRECT_CALL_OP
      && code != DECREMENT_SKIP_ZERO_OP |=>
      o_op_ready && o_pc == $past(o_pc) + PC_STEP)
      else $error("single cycle op did not step pc");
endmodule

// ===== tb/cise_exec_test.sv
`timescale 1ns/1ns
module cise_exec_test
   import cise_pkg::*;
;
   // Short prescaler keeps the watchdog period near 1024 cycles
   localparam int PW = 2;
   logic        i_clk, i_resetn, i_op_valid, i_wr, i_rd;
   cise_op_t    i_op;
   logic [7:0]  i_addr, i_wdata, o_rdata, o_accumulator, rv;
   logic [14:0] o_pc, p;
   logic        o_op_ready, o_zero_flag, o_skip, o_watchdog_timeout, z;
   logic        o_watchdog_expiry_flag_n, o_powerdown_flag_n;
   int          mismatches, total_checks, cycles;

   cise_exec #(.PRESCALE_W(PW)) cise_exec_i (.i_clk(i_clk),
      .i_resetn(i_resetn), .i_op_valid(i_op_valid), .i_op(i_op),
      .o_op_ready(o_op_ready), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_pc(o_pc),
      .o_accumulator(o_accumulator), .o_zero_flag(o_zero_flag),
      .o_watchdog_expiry_flag_n(o_watchdog_expiry_flag_n),
      .o_powerdown_flag_n(o_powerdown_flag_n), .o_skip(o_skip),
      .o_watchdog_timeout(o_watchdog_timeout));

   //-------------------------------------------------------------------
   // Clock, hang guard and verdict
   //-------------------------------------------------------------------
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   // Whole run needs about 1040 cycles
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         end_of_test();
      end
   end
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   //-------------------------------------------------------------------
   // Drivers
   //-------------------------------------------------------------------
   task automatic chk(string n, logic [14:0] e, logic [14:0] g);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   // Every input is assigned once per edge, so strobes never glitch
   task automatic cyc(logic w, logic r, logic v, logic [7:0] a,
                      logic [7:0] d, cise_op_t o);
      @(posedge i_clk);
      i_wr <= w;
      i_rd <= r;
      i_op_valid <= v;
      i_addr <= a;
      i_wdata <= d;
      i_op <= o;
   endtask
   task automatic idle;
      cyc(0, 0, 0, 8'h00, 8'h00, '0);
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      cyc(1, 0, 0, a, d, '0);
   endtask
   task automatic rd(logic [7:0] a, output logic [7:0] d);
      cyc(0, 1, 0, a, 8'h00, '0);
      idle();
      #1 d = o_rdata;
   endtask
   // Holds the offer until ready; caller decides what follows
   task automatic op(cise_opcode_t c, logic d, logic [6:0] f);
      cyc(0, 0, 1, 8'h00, 8'h00, '{c, d, f});
      #1;
      while (!o_op_ready) begin
         @(posedge i_clk);
         #1;
      end
   endtask

   //-------------------------------------------------------------------
   // Scenarios
   //-------------------------------------------------------------------
   task automatic t_reset;
      rd(ADDR_STATUS, rv);
      chk("status reset", 8'h06, rv);
      wr(ADDR_STATUS, 8'h00);
      rd(ADDR_STATUS, rv);
      chk("status read only", 8'h06, rv);
      rd(8'h40, rv);
      chk("unmapped read", 8'h00, rv);
   endtask

   task automatic t_file;
      cise_opcode_t c[6] = '{INVERT_FILE_OP, INVERT_FILE_OP, ZERO_FILE_OP,
         FILE_DECREMENT_OP, FILE_DECREMENT_OP, ZERO_ACCUMULATOR_OP};
      logic       dd[6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
      logic [7:0] iv[6] = '{8'hff, 8'h35, 8'h77, 8'h01, 8'h00, 8'h5a};
      logic [7:0] r, a, fv;
      for (int k = 0; k < 6; k++) begin
         r = (c[k] == INVERT_FILE_OP) ? ~iv[k] :
             (c[k] == FILE_DECREMENT_OP) ? iv[k] - 8'h01 : 8'h00;
         wr(ADDR_FILE_BASE | 8'h11, iv[k]);
         wr(ADDR_ACC, 8'h33);
         op(c[k], dd[k], 7'h11);
         rd(ADDR_ACC, a);
         rd(ADDR_FILE_BASE | 8'h11, fv);
         rd(ADDR_STATUS, rv);
         chk("acc", dd[k] ? 8'h33 : r, a);
         chk("file", (dd[k] || c[k] == ZERO_FILE_OP) ? r : iv[k], fv);
         chk("zero", r == 8'h00, rv[STAT_ZERO]);
      end
   endtask

   task automatic t_call;
      wr(ADDR_PC_LATCH, 8'h2a);
      wr(ADDR_ACC, 8'h5c);
      #1 z = o_zero_flag;
      p = o_pc;
      op(INDIRECT_CALL_OP, 1'b0, 7'h00);
      // Offer arrives in the stall cycle and must be dropped
      cyc(0, 0, 1, 8'h00, 8'h00, '{ZERO_ACCUMULATOR_OP, 1'b0, 7'h00});
      #1 chk("call stall", 1'b0, o_op_ready);
      idle();
      #1 chk("call pc", {7'h2a, 8'h5c}, o_pc);
      chk("refused offer", 8'h5c, o_accumulator);
      chk("call zero", z, o_zero_flag);
      rd(ADDR_TOS_LO, rv);
      chk("return lo", p[7:0] + 8'h01, rv);
      rd(ADDR_TOS_HI, rv);
      chk("return hi", {1'b0, p[14:8]}, rv);
   endtask

   task automatic t_skip;
      wr(ADDR_FILE_BASE | 8'h05, 8'h01);
      #1 z = o_zero_flag;
      p = o_pc;
      op(DECREMENT_SKIP_ZERO_OP, 1'b1, 7'h05);
      idle();
      #1 chk("skip pulse", 1'b1, o_skip);
      chk("skip stall", 1'b0, o_op_ready);
      idle();
      #1 chk("skip pc", p + 15'h0002, o_pc);
      chk("skip zero", z, o_zero_flag);
      rd(ADDR_FILE_BASE | 8'h05, rv);
      chk("skip file", 8'h00, rv);
      wr(ADDR_FILE_BASE | 8'h05, 8'h05);
      #1 p = o_pc;
      op(DECREMENT_SKIP_ZERO_OP, 1'b0, 7'h05);
      op(FILE_DECREMENT_OP, 1'b1, 7'h05);
      idle();
      #1 chk("no skip pc", p + 15'h0002, o_pc);
      chk("no skip acc", 8'h04, o_accumulator);
      rd(ADDR_FILE_BASE | 8'h05, rv);
      chk("back to back file", 8'h04, rv);
   endtask

   task automatic t_wdt;
      int n;
      n = 0;
      while (o_watchdog_timeout !== 1'b1 && n < 1100) begin
         idle();
         #1 n++;
      end
      chk("watchdog timeout", 1'b1, o_watchdog_timeout);
      idle();
      #1 chk("expiry", 1'b0, o_watchdog_expiry_flag_n);
      op(KICK_WATCHDOG_OP, 1'b0, 7'h00);
      rd(ADDR_WDT_PRE, rv);
      chk("prescaler", 8'h00, rv);
      rd(ADDR_WDT_CNT, rv);
      chk("counter", 8'h00, rv);
      chk("kick flags", 2'b11, {o_watchdog_expiry_flag_n,
                                o_powerdown_flag_n});
   endtask

   initial begin
      {i_wr, i_rd, i_op_valid, i_addr, i_wdata, i_op} = '0;
      i_resetn = 1'b0;
      repeat (2) @(posedge i_clk);
      i_resetn <= 1'b1;
      t_reset();
      t_file();
      t_call();
      t_skip();
      t_wdt();
      idle();
      end_of_test();
   end
endmodule

// Checker sits beside the core in every instance
bind cise_exec cise_exec_chk #(.PRESCALE_W(PRESCALE_W), .WDT_W(WDT_W),
   .STACK_DEPTH(STACK_DEPTH), .STACK_PTR_W(STACK_PTR_W)) cise_exec_chk_i (
   .i_clk(i_clk), .i_resetn(i_resetn), .i_op_valid(i_op_valid),
   .i_op(i_op), .o_op_ready(o_op_ready), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
   .o_pc(o_pc), .o_accumulator(o_accumulator), .o_zero_flag(o_zero_flag),
   .o_watchdog_expiry_flag_n(o_watchdog_expiry_flag_n),
   .o_powerdown_flag_n(o_powerdown_flag_n), .o_skip(o_skip),
   .o_watchdog_timeout(o_watchdog_timeout));
